//--- design/hpa_pkg.sv
// Constants, phase enumeration and timing figures for the host-port
// access sequencer. Assumes every count is in expansion-bus clocks.
package hpa_pkg;

  // ==========================================================
  // Phase enumeration
  typedef enum logic [2:0] {
    HPA_IDLE,
    HPA_ADDR,
    HPA_SETUP,
    HPA_STROBE,
    HPA_HOLD,
    HPA_RECOV
  } hpa_state_type;

  // ==========================================================
  // Phase settings: smallest value that software may program
  localparam logic [3:0] ADDR_SETTING_MIN = 4'h2;
  localparam logic [3:0] SETUP_SETTING_MIN = 4'h2;
  localparam logic [3:0] STROBE_SETTING_MIN = 4'h1;
  localparam logic [3:0] HOLD_SETTING_MIN = 4'h2;
  localparam logic [3:0] RECOV_SETTING_MIN = 4'h0;

  // A phase lasts its setting plus one clock; recovery plus two
  localparam logic [4:0] PHASE_EXTRA = 5'h01;
  localparam logic [4:0] RECOV_EXTRA = 5'h02;

  // Width of one host-port byte lane in byte-wide mode
  localparam int BYTE_W = 8;

  // ==========================================================
  // Gap between accesses, in bus clocks
  localparam int RECOV_CYCLES_MIN = 2;
  localparam int RECOV_CYCLES_MAX = 17;

  // ==========================================================
  // Reset values
  localparam hpa_state_type STATE_RST = HPA_IDLE;
  localparam logic [4:0] COUNT_RST = 5'h00;

endpackage

//--- design/hpa_timer_if.sv
// Carrier between the sequencer and its phase timer.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface hpa_timer_if;
  logic load;
  logic [4:0] load_val;
  logic done;

  modport ctrl (output load, output load_val, input done);
  modport timer (input load, input load_val, output done);
endinterface
`default_nettype wire

//--- design/hpa_phase_timer.sv
// Down-counter that times one sequencer phase in bus clocks.
// Assumes load is a one-cycle pulse given on phase entry.
`timescale 1ns/1ps
`default_nettype none
module hpa_phase_timer (
  input wire logic clk,
  input wire logic nrst,
  hpa_timer_if.timer tmr
);

  typedef struct packed {
    logic [4:0] count;
  } hpa_timer_state_type;

  hpa_timer_state_type tm_ff;
  hpa_timer_state_type nxt_tm;

  // ==========================================================
  // Counting
  // A load of N gives N cycles before done, N+1 with the done cycle; a bare zero stays done
  always_comb begin
    nxt_tm = tm_ff;
    if (tmr.load) begin
      nxt_tm.count = tmr.load_val;
    end else if (tm_ff.count != 5'h00) begin
      nxt_tm.count = tm_ff.count - 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tm_ff.count <= hpa_pkg::COUNT_RST;
    end else begin
      tm_ff <= nxt_tm;
    end
  end

  // Done depends on the count alone; gating it with load would close
  // a loop through the sequencer's advance decision
  assign tmr.done = (tm_ff.count == 5'h00);

endmodule
`default_nettype wire

//--- design/hpa_sequencer.sv
// Host-port access sequencer: drives one access at a time to an
// external DSP host port. Assumes all inputs are synchronous to clk.
//
// What this block does
// - A wait request is honoured only in the address and strobe phases.
// - While wait is high, address or strobe phase does not advance.
// - Address phase lasts one more clock after wait drops.
// - Strobe phase holds data setup one more clock after wait drops.
// - Address and chip select go active in the same clock.
// - In both host-port modes the address stays valid across the access.
// - Strobe goes active after the address and setup phases.
// - Write strobe pulse width follows the strobe setting.
// - Write data is valid before the strobe rises.
// - Write data stays valid through the hold phase.
// - Gap between accesses is two to seventeen clocks via recovery.
// - Every phase length is counted in bus clocks.
`timescale 1ns/1ps
`default_nettype none
module hpa_sequencer #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic resp_valid,
  output logic [DATA_W-1:0] resp_rdata,
  input wire logic muxed_halfword_host_port_mode,
  input wire logic [1:0] address_phase_setting,
  input wire logic [1:0] setup_phase_setting,
  input wire logic [3:0] strobe_phase_setting,
  input wire logic [1:0] hold_phase_setting,
  input wire logic [3:0] recovery_phase_setting,
  output logic setting_low,
  output logic busy,
  input wire logic dsp_wait_request,
  output logic hp_chip_select_n,
  output logic primary_data_strobe_n,
  output logic hp_write_n,
  output logic hp_addr_latch,
  output logic [ADDR_W-1:0] hp_addr,
  output logic [DATA_W-1:0] hp_data_out,
  output logic hp_data_oe,
  input wire logic [DATA_W-1:0] hp_data_in
);

  typedef struct packed {
    hpa_pkg::hpa_state_type state;
    logic wait_seen;
    logic is_write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic resp;
    logic cs;
    logic strobe;
    logic latch;
    logic oe;
    logic [DATA_W-1:0] dout;
    logic low;
  } hpa_seq_state_type;

  hpa_seq_state_type st_ff;
  hpa_seq_state_type nxt_st;
  hpa_timer_if tmr ();
  logic phase_go;

  // ==========================================================
  // Phase setting decode
  // Clamps a setting to its floor so a mis-programmed value cannot
  // shorten a phase below the point where a wait can be caught
  function automatic logic [4:0] clamp_setting(input logic [3:0] s,
                                               input logic [3:0] mn);
    clamp_setting = (s < mn) ? {1'b0, mn} : {1'b0, s};
  endfunction

  hpa_phase_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .tmr(tmr)
  );

  // ==========================================================
  // Phase advance
  // Wait is looked at in every cycle, and the cycle after it drops is
  // still spent in the phase, so one extra clock always follows
  assign phase_go = tmr.done && !dsp_wait_request
    && !st_ff.wait_seen;

  // ==========================================================
  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_st.resp = 1'b0;
    tmr.load = 1'b0;
    tmr.load_val = 5'h00;
    nxt_st.wait_seen = dsp_wait_request;
    nxt_st.low = (4'(address_phase_setting) < hpa_pkg::ADDR_SETTING_MIN)
      || (4'(setup_phase_setting) < hpa_pkg::SETUP_SETTING_MIN)
      || (strobe_phase_setting < hpa_pkg::STROBE_SETTING_MIN);
    case (st_ff.state)
      hpa_pkg::HPA_IDLE: begin
        if (req_valid) begin
          nxt_st.state = hpa_pkg::HPA_ADDR;
          nxt_st.addr = req_addr;
          nxt_st.wdata = req_wdata;
          nxt_st.is_write = req_write;
          tmr.load = 1'b1;
          tmr.load_val = clamp_setting(4'(address_phase_setting),
                                       hpa_pkg::ADDR_SETTING_MIN);
        end
      end
      hpa_pkg::HPA_ADDR: begin
        // Held while wait is up, plus one clock after it drops
        if (phase_go) begin
          nxt_st.state = hpa_pkg::HPA_SETUP;
          tmr.load = 1'b1;
          tmr.load_val = clamp_setting(4'(setup_phase_setting),
                                       hpa_pkg::SETUP_SETTING_MIN);
        end
      end
      hpa_pkg::HPA_SETUP: begin
        // Setup is not stretched by wait; strobe phase catches it
        if (tmr.done) begin
          nxt_st.state = hpa_pkg::HPA_STROBE;
          tmr.load = 1'b1;
          tmr.load_val = clamp_setting(strobe_phase_setting,
                                       hpa_pkg::STROBE_SETTING_MIN);
        end
      end
      hpa_pkg::HPA_STROBE: begin
        if (phase_go) begin
          nxt_st.state = hpa_pkg::HPA_HOLD;
          tmr.load = 1'b1;
          tmr.load_val = clamp_setting(4'(hold_phase_setting),
                                       hpa_pkg::HOLD_SETTING_MIN);
          // Read data is taken as the strobe goes away
          if (!st_ff.is_write) begin
            nxt_st.rdata = muxed_halfword_host_port_mode ? hp_data_in
              : DATA_W'(hp_data_in[hpa_pkg::BYTE_W-1:0]);
          end
        end
      end
      hpa_pkg::HPA_HOLD: begin
        if (tmr.done) begin
          nxt_st.state = hpa_pkg::HPA_RECOV;
          nxt_st.resp = 1'b1;
          tmr.load = 1'b1;
          tmr.load_val = clamp_setting(recovery_phase_setting,
            hpa_pkg::RECOV_SETTING_MIN) + hpa_pkg::RECOV_EXTRA
            - hpa_pkg::PHASE_EXTRA;
        end
      end
      hpa_pkg::HPA_RECOV: begin
        // No new access is taken until the gap has run out
        if (tmr.done) begin
          nxt_st.state = hpa_pkg::HPA_IDLE;
        end
      end
      default: begin
        nxt_st.state = hpa_pkg::HPA_IDLE;
      end
    endcase

    // Pin levels follow the coming phase so they leave flip-flops
    // aligned to the phase boundary
    nxt_st.cs = (nxt_st.state == hpa_pkg::HPA_ADDR)
      || (nxt_st.state == hpa_pkg::HPA_SETUP)
      || (nxt_st.state == hpa_pkg::HPA_STROBE)
      || (nxt_st.state == hpa_pkg::HPA_HOLD);
    nxt_st.strobe = (nxt_st.state == hpa_pkg::HPA_STROBE);
    nxt_st.latch = muxed_halfword_host_port_mode
      && (nxt_st.state == hpa_pkg::HPA_ADDR);
    // Data is driven from setup through hold, so it is up before the
    // strobe and stays after it rises
    nxt_st.oe = nxt_st.latch || (nxt_st.is_write && nxt_st.cs
      && (nxt_st.state != hpa_pkg::HPA_ADDR));
    if (nxt_st.latch) begin
      nxt_st.dout = DATA_W'(nxt_st.addr);
    end else if (muxed_halfword_host_port_mode) begin
      nxt_st.dout = nxt_st.wdata;
    end else begin
      nxt_st.dout = DATA_W'(nxt_st.wdata[hpa_pkg::BYTE_W-1:0]);
    end
  end

  // ==========================================================
  // State register, advanced on every bus clock
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff.state <= hpa_pkg::STATE_RST;
      st_ff.wait_seen <= 1'b0;
      st_ff.is_write <= 1'b0;
      st_ff.addr <= '0;
      st_ff.wdata <= '0;
      st_ff.rdata <= '0;
      st_ff.resp <= 1'b0;
      st_ff.cs <= 1'b0;
      st_ff.strobe <= 1'b0;
      st_ff.latch <= 1'b0;
      st_ff.oe <= 1'b0;
      st_ff.dout <= '0;
      st_ff.low <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs
  // Address stays on its pins for the whole access in both modes
  assign hp_addr = st_ff.addr;
  assign hp_chip_select_n = !st_ff.cs;
  assign primary_data_strobe_n = !st_ff.strobe;
  assign hp_write_n = !(st_ff.is_write && st_ff.cs);
  assign hp_addr_latch = st_ff.latch;
  assign hp_data_out = st_ff.dout;
  assign hp_data_oe = st_ff.oe;
  assign resp_valid = st_ff.resp;
  assign resp_rdata = st_ff.rdata;
  assign setting_low = st_ff.low;
  assign busy = (st_ff.state != hpa_pkg::HPA_IDLE);
  assign req_ready = (st_ff.state == hpa_pkg::HPA_IDLE);

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Recovery length counter, read only by the checks
  logic [4:0] rec_cnt_ff;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rec_cnt_ff <= 5'h00;
    end else if (st_ff.state == hpa_pkg::HPA_RECOV) begin
      rec_cnt_ff <= rec_cnt_ff + 5'h01;
    end else begin
      rec_cnt_ff <= 5'h00;
    end
  end

  sequence s_enter_addr;
    st_ff.state != hpa_pkg::HPA_ADDR ##1 st_ff.state == hpa_pkg::HPA_ADDR;
  endsequence

  sequence s_enter_setup;
    st_ff.state != hpa_pkg::HPA_SETUP ##1 st_ff.state == hpa_pkg::HPA_SETUP;
  endsequence

  sequence s_enter_strobe;
    st_ff.state != hpa_pkg::HPA_STROBE ##1 st_ff.state == hpa_pkg::HPA_STROBE;
  endsequence

  chk_addr_len_min: assert property (
    s_enter_addr |-> (st_ff.state == hpa_pkg::HPA_ADDR) [*3])
    else $error("address phase shorter than three clocks");

  chk_setup_len_min: assert property (
    s_enter_setup |-> (st_ff.state == hpa_pkg::HPA_SETUP) [*3])
    else $error("setup phase shorter than three clocks");

  chk_strobe_len_min: assert property (
    s_enter_strobe |-> (!primary_data_strobe_n) [*2])
    else $error("strobe shorter than two clocks");

  chk_wait_holds_phase: assert property (
    (dsp_wait_request && (st_ff.state == hpa_pkg::HPA_ADDR
      || st_ff.state == hpa_pkg::HPA_STROBE)) |=> $stable(st_ff.state))
    else $error("phase left while wait active");

  chk_addr_after_wait: assert property (
    (st_ff.state == hpa_pkg::HPA_ADDR && !dsp_wait_request
      && $past(dsp_wait_request)) |=> st_ff.state == hpa_pkg::HPA_ADDR)
    else $error("address phase left right after wait dropped");

  chk_strobe_after_wait: assert property (
    (st_ff.state == hpa_pkg::HPA_STROBE && !dsp_wait_request
      && $past(dsp_wait_request)) |=> !primary_data_strobe_n)
    else $error("strobe ended right after wait dropped");

  chk_cs_with_addr: assert property (
    $fell(hp_chip_select_n) |-> $changed(st_ff.state)
      && st_ff.state == hpa_pkg::HPA_ADDR && hp_addr == $past(req_addr))
    else $error("chip select not aligned with address phase");

  chk_data_before_strobe: assert property (
    ($fell(primary_data_strobe_n) && st_ff.is_write) |-> hp_data_oe
      && $past(hp_data_oe))
    else $error("write data not valid before strobe");

  chk_data_hold: assert property (
    ($rose(primary_data_strobe_n) && st_ff.is_write) |-> hp_data_oe [*3])
    else $error("write data dropped too soon after strobe");

  chk_recov_gap: assert property (
    (st_ff.state == hpa_pkg::HPA_RECOV ##1 st_ff.state != hpa_pkg::HPA_RECOV)
      |-> (int'(rec_cnt_ff) >= hpa_pkg::RECOV_CYCLES_MIN)
      && (int'(rec_cnt_ff) <= hpa_pkg::RECOV_CYCLES_MAX))
    else $error("recovery gap out of range");

  chk_phase_order: assert property (
    (st_ff.state == hpa_pkg::HPA_HOLD) |=> (st_ff.state == hpa_pkg::HPA_HOLD)
      || (st_ff.state == hpa_pkg::HPA_RECOV && $past(tmr.done)))
    else $error("hold not followed by recovery");

endmodule
`default_nettype wire

//--- verif/hpa_dsp_model.sv
// Behavioural far-end host port: raises the wait request on command and
// returns a fixed read word while selected. Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
module hpa_dsp_model #(
  parameter logic [15:0] READ_WORD = 16'h5a3c
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hp_chip_select_n,
  input wire logic primary_data_strobe_n,
  input wire logic [1:0] stall_sel,
  input wire logic [3:0] stall_len,
  output logic dsp_wait_request,
  output logic [15:0] hp_data_in
);
  logic [3:0] left_ff;
  logic cs_d_ff;
  logic st_d_ff;
  logic [15:0] last_ff;
  logic start;
  // ==========================================================
  // Stall start: phase entry seen on the registered select or strobe
  assign start = (stall_sel == 2'h1 && cs_d_ff && !hp_chip_select_n) ||
                 (stall_sel == 2'h2 && st_d_ff && !primary_data_strobe_n);
  assign dsp_wait_request = start || (left_ff != 4'h0);
  // Deselected lines toggle so a stale value is never mistaken for data
  assign hp_data_in = !hp_chip_select_n ? READ_WORD : ~last_ff;
  // Wait length counter, edge memories
  always_ff @(posedge clk) begin
    last_ff <= hp_data_in;
    if (!nrst) begin
      left_ff <= 4'h0;
      cs_d_ff <= 1'b1;
      st_d_ff <= 1'b1;
    end else begin
      cs_d_ff <= hp_chip_select_n;
      st_d_ff <= primary_data_strobe_n;
      if (left_ff != 4'h0) left_ff <= left_ff - 4'h1;
      else if (start) left_ff <= stall_len - 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the host-port sequencer with a DSP model.
// Assumes inputs change on the falling edge and settings stay stable.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic wr; logic md; logic [1:0] a; logic [1:0] s;
    logic [3:0] t; logic [1:0] h; logic [3:0] r;
    logic [15:0] addr; logic [15:0] wdata;
  } hpa_row_type;
  logic clk = 1'b0, nrst = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000;
  logic md = 1'b0;
  logic [1:0] a_set = 2'h2, s_set = 2'h2, h_set = 2'h2, stall_sel = 2'h0;
  logic [3:0] t_set = 4'h1, r_set = 4'h0, stall_len = 4'h1;
  logic req_ready, resp_valid, setting_low, busy, wait_req, cs_n, st_n;
  logic write_n, latch, oe;
  logic [15:0] resp_rdata, hp_addr, dout, din;
  int bad_count = 0;
  int samples_checked = 0;
  hpa_row_type rows [5] = '{
    {1'b1, 1'b0, 2'h2, 2'h2, 4'h1, 2'h2, 4'h0, 16'h1234, 16'ha5c3},
    {1'b0, 1'b0, 2'h2, 2'h2, 4'h1, 2'h2, 4'hf, 16'h00ff, 16'h0000},
    {1'b1, 1'b1, 2'h3, 2'h3, 4'h4, 2'h3, 4'h3, 16'hbeef, 16'h7e81},
    {1'b0, 1'b1, 2'h3, 2'h2, 4'hf, 2'h2, 4'h1, 16'h8001, 16'h0000},
    {1'b1, 1'b0, 2'h0, 2'h1, 4'h0, 2'h0, 4'h2, 16'h4321, 16'h0f96}};
  always #12.5 clk = ~clk;
  hpa_sequencer i_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .muxed_halfword_host_port_mode(md),
    .address_phase_setting(a_set), .setup_phase_setting(s_set),
    .strobe_phase_setting(t_set), .hold_phase_setting(h_set),
    .recovery_phase_setting(r_set), .setting_low(setting_low),
    .busy(busy), .dsp_wait_request(wait_req), .hp_chip_select_n(cs_n),
    .primary_data_strobe_n(st_n), .hp_write_n(write_n),
    .hp_addr_latch(latch), .hp_addr(hp_addr), .hp_data_out(dout),
    .hp_data_oe(oe), .hp_data_in(din));
  hpa_dsp_model i_dsp (.clk(clk), .nrst(nrst), .hp_chip_select_n(cs_n),
    .primary_data_strobe_n(st_n), .stall_sel(stall_sel),
    .stall_len(stall_len), .dsp_wait_request(wait_req),
    .hp_data_in(din));
  // ==========================================================
  // Compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One access, timed from the falling edge; counts in bus clocks
  task automatic run(input hpa_row_type r, input logic [1:0] ss,
                     input logic [3:0] sl, input logic poke);
    int a, s, t, h, cyc, csf, stf, stc, csc, rsp, rdy, rn;
    logic [15:0] sd;
    logic so;
    a = (r.a < 2 ? 2 : r.a) + 1;
    s = (r.s < 2 ? 2 : r.s) + 1;
    t = (r.t < 1 ? 1 : r.t) + 1;
    h = (r.h < 2 ? 2 : r.h) + 1;
    csf = -1; stf = -1; stc = 0; csc = 0; rsp = -1; rdy = -1; rn = 0;
    md = r.md; a_set = r.a; s_set = r.s; t_set = r.t; h_set = r.h;
    r_set = r.r; stall_sel = ss; stall_len = sl;
    req_valid = 1'b1; req_write = r.wr; req_addr = r.addr;
    req_wdata = r.wdata;
    @(negedge clk);
    for (cyc = 1; cyc < 300 && rdy < 0; cyc++) begin
      if (!cs_n) begin
        csc++;
        if (csf < 0) begin
          csf = cyc;
          check(hp_addr, r.addr);
          check(write_n, !r.wr);
          check(latch, r.md);
          if (r.md) check(dout, r.addr);
        end
      end
      if (!st_n) begin
        stc++;
        if (stf < 0) stf = cyc;
        sd = dout;
        so = oe;
      end
      if (resp_valid) begin
        rn++;
        rsp = cyc;
      end
      if (req_ready && rsp > 0) rdy = cyc;
      req_valid = poke && cyc == 4;
      @(negedge clk);
    end
    check(csf, 1);
    check(rn, 1);
    check(rdy - rsp, r.r + 2);
    check(setting_low, r.a < 2 || r.s < 2 || r.t < 1);
    check(so, r.wr);
    if (r.wr) check(sd, r.md ? r.wdata : {8'h00, r.wdata[7:0]});
    else if (r.md) check(resp_rdata, 16'h5a3c);
    else check(resp_rdata, 16'h003c);
    if (ss == 2'h1) begin
      check(stf - 1 - s >= sl + 1 && stf - 1 - s <= sl + a + 1, 1);
    end else begin
      check(stf - csf, a + s);
    end
    if (ss == 2'h2) begin
      check(stc >= sl + 1 && stc <= sl + t + 1, 1);
    end else begin
      check(stc, t);
    end
    if (ss == 2'h0) check(csc, a + s + t + h);
    if (ss == 2'h0) check(rsp, a + s + t + h + 1);
  endtask
  // ==========================================================
  // Watchdog: the whole run needs well under two thousand clocks
  initial begin
    #(25 * 20000);
    bad_count++;
    print_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    check({cs_n, st_n, busy, req_ready, oe}, 5'h1a);
    nrst = 1'b1;
    @(negedge clk);
    foreach (rows[i]) begin
      run(rows[i], 2'h0, 4'h1, 1'b0);
      $display("table test %0d done", i);
    end
    run(rows[2], 2'h1, 4'h5, 1'b1);
    $display("address stall test done");
    run(rows[0], 2'h2, 4'h6, 1'b0);
    $display("strobe stall test done");
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    check({cs_n, st_n, busy, req_ready}, 4'hd);
    nrst = 1'b1;
    @(negedge clk);
    run(rows[3], 2'h0, 4'h1, 1'b0);
    $display("reset mid access test done");
    print_verdict();
  end
endmodule
`default_nettype wire
